// ===== ums_pkg.sv
package ums_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ  = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  // mode control bit positions
  localparam int MODE_SYNC = 0;
  localparam int MODE_ATTN = 1;
  localparam int MODE_BRK  = 2;
  localparam int MODE_CKS  = 3;
  localparam int MODE_TDMA = 4;
  localparam int MODE_RDMA = 5;
  localparam int MODE_FCI  = 6;
  localparam int MODE_RTS  = 7;
  // line status bit positions
  localparam int ST_PE   = 0;
  localparam int ST_FE   = 1;
  localparam int ST_OE   = 2;
  localparam int ST_ERR  = 3;
  localparam int ST_BKD  = 4;
  localparam int ST_RB9  = 5;
  localparam int ST_XMIP = 6;
  // interrupt bit for end of transmission
  localparam int IRQ_TXDONE = 7;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] IRQ_RST  = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // break needs this many bit times low
  localparam logic [3:0] BRK_BITS = 4'ha;
  // apb answer sequencing
  typedef enum logic {AP_IDLE, AP_DONE} ums_apb_t;
endpackage : ums_pkg

// ===== ums_stat_if.sv
`timescale 1ns/10ps
interface ums_stat_if;
  logic       ev_pe;
  logic       ev_fe;
  logic       ev_oe;
  logic       ev_done;
  logic       stop_missing;
  logic       ninth;
  logic       nine_mode;
  logic       rx_line;
  logic       bit_tick;
  logic       tx_active;
  logic       rd_clr;
  logic [7:0] flags;
  modport ctl (output ev_pe, ev_fe, ev_oe, ev_done, stop_missing, ninth,
               nine_mode, rx_line, bit_tick, tx_active, rd_clr,
               input flags);
  modport stat (input ev_pe, ev_fe, ev_oe, ev_done, stop_missing, ninth,
                nine_mode, rx_line, bit_tick, tx_active, rd_clr,
                output flags);
endinterface : ums_stat_if

// ===== ums_status_flags.sv
`timescale 1ns/10ps
module ums_status_flags (
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  ce,
  ums_stat_if.stat  st
);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [3:0] brk_cnt_r;
  logic       brk_arm_r;
  logic       bkd_pend_r;
  logic       brk_hit;
  logic       err_flags;

  // ten ticks of low line after a missing stop bit
  assign brk_hit = brk_arm_r && st.bit_tick && !st.rx_line &&
                   (brk_cnt_r == ums_pkg::BRK_BITS - 4'h1);
  assign err_flags = flags_nxt[ums_pkg::ST_PE] |
                     flags_nxt[ums_pkg::ST_FE] | flags_nxt[ums_pkg::ST_OE];

  // next flags: a hardware set always wins over a read clear
  always_comb begin
    flags_nxt = flags_r;
    flags_nxt[ums_pkg::ST_PE] = st.ev_pe |
                                (flags_r[ums_pkg::ST_PE] & ~st.rd_clr);
    flags_nxt[ums_pkg::ST_FE] = st.ev_fe |
                                (flags_r[ums_pkg::ST_FE] & ~st.rd_clr);
    flags_nxt[ums_pkg::ST_OE] = st.ev_oe |
                                (flags_r[ums_pkg::ST_OE] & ~st.rd_clr);
    flags_nxt[ums_pkg::ST_ERR] = err_flags;
    // break flag, held while the line is low
    flags_nxt[ums_pkg::ST_BKD] = brk_hit | (flags_r[ums_pkg::ST_BKD] &
      ~((st.rd_clr | bkd_pend_r) & st.rx_line));
    if (st.ev_done && st.nine_mode)
      flags_nxt[ums_pkg::ST_RB9] = st.ninth;
    flags_nxt[ums_pkg::ST_XMIP] = st.tx_active;
    flags_nxt[7] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flags_r <= ums_pkg::STAT_RST;
    else if (ce) flags_r <= flags_nxt;
  end

  // break timer: restarts on every frame, abandons on a high line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_arm_r <= 1'b0;
      brk_cnt_r <= 4'h0;
    end else if (ce) begin
      if (st.ev_done) begin
        brk_arm_r <= st.stop_missing;
        brk_cnt_r <= 4'h0;
      end else if (st.rx_line || brk_hit) begin
        brk_arm_r <= 1'b0;
      end else if (st.bit_tick) begin
        brk_cnt_r <= brk_cnt_r + 4'h1;
      end
    end
  end

  // a read during break is remembered until the line rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bkd_pend_r <= 1'b0;
    else if (ce) bkd_pend_r <= flags_nxt[ums_pkg::ST_BKD] &&
                               (bkd_pend_r || st.rd_clr);
  end

  assign st.flags = flags_r;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_parity_flag_set: assert property (
    ce && st.ev_pe |=> flags_r[ums_pkg::ST_PE] && flags_r[ums_pkg::ST_ERR])
    else $error("parity event did not set flag and summary");
  chk_frame_flag_set: assert property (
    ce && st.ev_fe |=> flags_r[ums_pkg::ST_FE])
    else $error("framing event did not set flag");
  chk_overrun_flag_set: assert property (
    ce && st.ev_oe |=> flags_r[ums_pkg::ST_OE])
    else $error("overrun event did not set flag");
  chk_read_clears_err: assert property (
    ce && st.rd_clr && !st.ev_pe && !st.ev_fe && !st.ev_oe
    |=> !flags_r[ums_pkg::ST_ERR])
    else $error("status read left error summary set");
  chk_break_flag_set: assert property (
    ce && brk_hit |=> flags_r[ums_pkg::ST_BKD])
    else $error("ten low bit times did not flag break");
  chk_break_flag_hold: assert property (
    ce && flags_r[ums_pkg::ST_BKD] && !st.rx_line
    |=> flags_r[ums_pkg::ST_BKD])
    else $error("break flag cleared while line low");
  chk_ninth_bit_take: assert property (
    ce && st.ev_done && st.nine_mode
    |=> flags_r[ums_pkg::ST_RB9] == $past(st.ninth))
    else $error("ninth bit not captured");
  chk_tx_busy_flag: assert property (
    ce |=> flags_r[ums_pkg::ST_XMIP] == $past(st.tx_active))
    else $error("transmit flag does not follow shifter");
endmodule : ums_status_flags

// ===== ums_uart_mode_status.sv
`timescale 1ns/10ps
// Function
// - mode control register resets to all zeros.
// - mode bits 0..7: sync, attention, break, clock, tdma, rdma, fci, rts.
// - synchronous mode can be set only on channel zero.
// - break bit set holds the transmit output low until cleared.
// - software writes to the line status register are ignored.
// - line status register resets to all zeros.
// - parity mismatch sets bit 0; a status read clears it.
// - missing stop bit sets bit 1; a status read clears it.
// - character arriving over an unread one sets bit 2; read clears.
// - line low ten bit times after missing stop sets bit 4.
module ums_uart_mode_status #(
  parameter int CHANNEL = 0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_line,
  input  wire logic        bit_tick,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_parity_bad,
  input  wire logic        rx_stop_missing,
  input  wire logic        rx_nine_bit,
  input  wire logic        rx_ninth_bit,
  input  wire logic        rx_buf_unread,
  input  wire logic        tx_shift_active,
  input  wire logic        tx_serial,
  output logic             txd,
  output logic             sync_async_select,
  output logic             attention_mode_enable,
  output logic             break_generate,
  output logic             sync_clock_source_select,
  output logic             transmit_dma_enable,
  output logic             receive_dma_enable,
  output logic             flow_control_irq_enable,
  output logic             request_to_send_level,
  output logic             irq
);
  ums_stat_if stif ();

  ums_pkg::ums_apb_t ap_r;
  logic [7:0]  mode_r;
  logic [7:0]  irq_st_r;
  logic [7:0]  irq_mask_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        txd_r;
  logic        irq_r;
  logic        tx_act_d_r;
  logic [7:0]  mode_nxt;
  logic [7:0]  irq_st_nxt;
  logic [7:0]  irq_mask_nxt_w;
  logic [7:0]  events;
  logic [7:0]  rd_mux;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit_mode;
  logic        hit_stat;
  logic        hit_irq;
  logic        hit_mask;
  logic        mapped;
  logic        tx_done;
  logic        ev_pe;
  logic        ev_fe;
  logic        ev_oe;

  // decode of the access phase; answer comes one cycle later
  assign acc      = psel && penable && (ap_r == ums_pkg::AP_IDLE);
  assign wr_acc   = acc && pwrite;
  assign rd_acc   = acc && !pwrite;
  assign hit_mode = paddr == ums_pkg::ADDR_MODE;
  assign hit_stat = paddr == ums_pkg::ADDR_STAT;
  assign hit_irq  = paddr == ums_pkg::ADDR_IRQ;
  assign hit_mask = paddr == ums_pkg::ADDR_MASK;
  assign mapped   = hit_mode | hit_stat | hit_irq | hit_mask;

  // receive side events from the deserialiser
  assign ev_pe   = rx_frame_done && rx_parity_bad;
  assign ev_fe   = rx_frame_done && rx_stop_missing;
  assign ev_oe   = rx_frame_done && rx_buf_unread;
  assign tx_done = tx_act_d_r && !tx_shift_active;

  // hand the events and the read side effect to the flag keeper
  assign stif.ev_pe        = ev_pe;
  assign stif.ev_fe        = ev_fe;
  assign stif.ev_oe        = ev_oe;
  assign stif.ev_done      = rx_frame_done;
  assign stif.stop_missing = rx_stop_missing;
  assign stif.ninth        = rx_ninth_bit;
  assign stif.nine_mode    = rx_nine_bit;
  assign stif.rx_line      = rx_line;
  assign stif.bit_tick     = bit_tick;
  assign stif.tx_active    = tx_shift_active;
  assign stif.rd_clr       = rd_acc && hit_stat;

  ums_status_flags u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .st      (stif.stat)
  );

  // mode register write
  always_comb begin
    mode_nxt = mode_r;
    // bit layout follows the package positions
    if (wr_acc && hit_mode)
      mode_nxt = pwdata[7:0];
    // only channel zero keeps the sync bit
    if (CHANNEL != 0)
      mode_nxt[ums_pkg::MODE_SYNC] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_r <= ums_pkg::MODE_RST;
    else if (ce) mode_r <= mode_nxt;
  end

  localparam int IRQ_TXDONE_BIT = ums_pkg::IRQ_TXDONE;

  // event vector in the same layout as the status bits
  always_comb begin
    events = 8'h00;
    events[ums_pkg::ST_PE]      = ev_pe;
    events[ums_pkg::ST_FE]      = ev_fe;
    events[ums_pkg::ST_OE]      = ev_oe;
    events[ums_pkg::ST_BKD]     = stif.flags[ums_pkg::ST_BKD];
    events[IRQ_TXDONE_BIT]      = tx_done;
  end

  // sticky interrupt bits, write one to clear; set wins
  assign irq_st_nxt = events |
    (irq_st_r & ~((wr_acc && hit_irq) ? pwdata[7:0] : 8'h00));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r   <= ums_pkg::IRQ_RST;
      irq_mask_r <= ums_pkg::MASK_RST;
      tx_act_d_r <= 1'b0;
    end else if (ce) begin
      irq_st_r   <= irq_st_nxt;
      tx_act_d_r <= tx_shift_active;
      if (wr_acc && hit_mask) irq_mask_r <= pwdata[7:0];
    end
  end

  // read data selection; status writes fall through untouched
  // status has no write path
  assign rd_mux = hit_mode ? mode_r :
                  hit_stat ? stif.flags :
                  hit_irq  ? irq_st_r :
                  hit_mask ? irq_mask_r : 8'h00;

  // apb answer: pready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ap_r      <= ums_pkg::AP_IDLE;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (ce) begin
      case (ap_r)
        ums_pkg::AP_IDLE: begin
          if (acc) begin
            ap_r      <= ums_pkg::AP_DONE;
            pready_r  <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r  <= {24'h00_0000, pwrite ? 8'h00 : rd_mux};
          end
        end
        ums_pkg::AP_DONE: begin
          ap_r      <= ums_pkg::AP_IDLE;
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
        end
        default: ap_r <= ums_pkg::AP_IDLE;
      endcase
    end
  end

  // transmit pin and interrupt line, both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_r <= 1'b1;
      irq_r <= 1'b0;
    end else if (ce) begin
      txd_r <= mode_nxt[ums_pkg::MODE_BRK] ? 1'b0 : tx_serial;
      irq_r <= |(irq_st_nxt & irq_mask_nxt_w);
    end
  end

  assign irq_mask_nxt_w = (wr_acc && hit_mask) ? pwdata[7:0] : irq_mask_r;

  assign prdata                   = prdata_r;
  assign pready                   = pready_r;
  assign pslverr                  = pslverr_r;
  assign txd                      = txd_r;
  assign irq                      = irq_r;
  assign sync_async_select        = mode_r[ums_pkg::MODE_SYNC];
  assign attention_mode_enable    = mode_r[ums_pkg::MODE_ATTN];
  assign break_generate           = mode_r[ums_pkg::MODE_BRK];
  assign sync_clock_source_select = mode_r[ums_pkg::MODE_CKS];
  assign transmit_dma_enable      = mode_r[ums_pkg::MODE_TDMA];
  assign receive_dma_enable       = mode_r[ums_pkg::MODE_RDMA];
  assign flow_control_irq_enable  = mode_r[ums_pkg::MODE_FCI];
  assign request_to_send_level    = mode_r[ums_pkg::MODE_RTS];

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a setup phase followed by an access and a one-cycle answer
  sequence s_access;
    psel && !penable ##1 psel && penable && ce && ap_r == ums_pkg::AP_IDLE;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  chk_apb_answer_time: assert property (
    s_access |=> s_answer)
    else $error("apb answer not one cycle after access");
  chk_mode_after_reset: assert property (
    $rose(presetn) |-> mode_r == ums_pkg::MODE_RST)
    else $error("mode register not zero after reset");
  chk_mode_rts_write: assert property (
    ce && wr_acc && hit_mode
    |=> request_to_send_level == $past(pwdata[ums_pkg::MODE_RTS])
        && break_generate == $past(pwdata[ums_pkg::MODE_BRK]))
    else $error("mode write not stored in place");
  chk_sync_only_zero: assert property (
    CHANNEL != 0 |-> !sync_async_select)
    else $error("sync mode set on a later channel");
  chk_break_holds_low: assert property (
    break_generate |-> !txd)
    else $error("transmit line not low during break");
  chk_stat_write_dropped: assert property (
    ce && wr_acc && hit_stat
    |=> ($past(stif.flags[2:0]) & ~stif.flags[2:0]) == 3'h0)
    else $error("status write had an effect");
  chk_stat_after_reset: assert property (
    $rose(presetn) |-> stif.flags == ums_pkg::STAT_RST)
    else $error("status not zero after reset");
  chk_irq_follows_mask: assert property (
    ce |=> irq == |(irq_st_r & irq_mask_r))
    else $error("interrupt line disagrees with status and mask");
endmodule : ums_uart_mode_status

// ===== ums_peer_model.sv
`timescale 1ns/10ps
// far transmitter, seen through the receive front end
module ums_peer_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      rx_line,
  output logic      bit_tick,
  output logic      rx_frame_done,
  output logic      rx_parity_bad,
  output logic      rx_stop_missing,
  output logic      rx_nine_bit,
  output logic      rx_ninth_bit,
  output logic      rx_buf_unread
);
  logic [7:0] div_r;

  // bit time strobe runs free, like a real baud divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_r <= 8'h00;
    else div_r <= bit_tick ? 8'h00 : div_r + 8'h01;
  end
  assign bit_tick = (div_r == 8'(TICK_DIV - 1));

  // idle line high, no frame pending
  initial begin
    rx_line = 1'b1;
    {rx_frame_done, rx_nine_bit} = 2'b00;
    {rx_parity_bad, rx_stop_missing, rx_ninth_bit, rx_buf_unread} = 4'h5;
  end

  // f = parity bad, stop missing, nine mode, ninth bit, unread
  task automatic send_frame(input logic [4:0] f, input logic after);
    rx_nine_bit <= f[2];
    rx_line <= ~f[3];
    rx_frame_done <= 1'b1;
    {rx_parity_bad, rx_stop_missing, rx_ninth_bit, rx_buf_unread}
      <= {f[4], f[3], f[1], f[0]};
    @(posedge pclk);
    // qualifiers flip once the pulse is gone, so nothing leans on them
    rx_frame_done <= 1'b0;
    {rx_parity_bad, rx_stop_missing, rx_ninth_bit, rx_buf_unread}
      <= ~{f[4], f[3], f[1], f[0]};
    rx_line <= after;
  endtask : send_frame

  task automatic set_line(input logic v);
    rx_line <= v;
  endtask : set_line
endmodule : ums_peer_model

// ===== tb_uart_mode_and_status.sv
`timescale 1ns/10ps
module tb_uart_mode_and_status;
  typedef struct packed {
    logic [4:0] frame;
    logic [7:0] stat;
  } ums_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_line, bit_tick, rx_frame_done, rx_parity_bad, txd, irq;
  logic        rx_stop_missing, rx_nine_bit, rx_ninth_bit, rx_buf_unread;
  logic        tx_shift_active, tx_serial, err;
  logic        ce;
  logic [1:0]  ch1_mode;
  logic [7:0]  paddr, mode_pins, mv;
  logic [31:0] pwdata, prdata, rd;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  // frame kind beside the status it should leave
  ums_row_t    rows [5] = '{'{5'b10000, 8'h09}, '{5'b01000, 8'h0a},
                            '{5'b00001, 8'h0c}, '{5'b11001, 8'h0f},
                            '{5'b00110, 8'h20}};

  ums_uart_mode_status #(.CHANNEL(0)) i_dut (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_line, .bit_tick,
    .rx_frame_done, .rx_parity_bad, .rx_stop_missing, .rx_nine_bit,
    .rx_ninth_bit, .rx_buf_unread, .tx_shift_active, .tx_serial, .txd,
    .sync_async_select(mode_pins[0]), .attention_mode_enable(mode_pins[1]),
    .break_generate(mode_pins[2]), .sync_clock_source_select(mode_pins[3]),
    .transmit_dma_enable(mode_pins[4]), .receive_dma_enable(mode_pins[5]),
    .flow_control_irq_enable(mode_pins[6]),
    .request_to_send_level(mode_pins[7]), .irq);

  ums_peer_model i_peer (
    .pclk, .presetn, .rx_line, .bit_tick, .rx_frame_done, .rx_parity_bad,
    .rx_stop_missing, .rx_nine_bit, .rx_ninth_bit, .rx_buf_unread);

  // a later channel sees the same writes but must refuse sync mode
  ums_uart_mode_status #(.CHANNEL(1)) i_dut_ch1 (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata(), .pready(), .pslverr(), .rx_line, .bit_tick,
    .rx_frame_done, .rx_parity_bad, .rx_stop_missing, .rx_nine_bit,
    .rx_ninth_bit, .rx_buf_unread, .tx_shift_active, .tx_serial, .txd(),
    .sync_async_select(ch1_mode[0]), .attention_mode_enable(ch1_mode[1]),
    .break_generate(), .sync_clock_source_select(),
    .transmit_dma_enable(), .receive_dma_enable(),
    .flow_control_irq_enable(), .request_to_send_level(), .irq());

  // 10 MHz clock
  always #50 pclk = ~pclk;

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one transfer, then an idle edge so no signal is driven twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n >= 16) chk(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, exp});
    chk({31'h0, err}, 32'h0);
  endtask : rd_chk

  task automatic st_chk(input logic [7:0] exp);
    rd_chk(ums_pkg::ADDR_STAT, exp);
  endtask : st_chk

  // hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, tx_shift_active} = 4'h0;
    tx_serial = 1'b1;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({22'h0, mode_pins, txd, irq}, 32'h2); // pins after reset
    rd_chk(ums_pkg::ADDR_MODE, 8'h00); // mode cleared
    st_chk(8'h00); // status cleared
    $display("reset test done");
    // each frame kind, then a second read sees the errors gone
    foreach (rows[i]) begin
      i_peer.send_frame(rows[i].frame, 1'b1);
      repeat (2) @(posedge pclk);
      st_chk(rows[i].stat); // flags set
      apb(1'b0, ums_pkg::ADDR_STAT, 32'h0);
      chk(rd & 32'h0f, 32'h0); // read clears
    end
    $display("frame table done");
    // each mode bit alone, then all of them
    for (int i = 0; i < 9; i++) begin
      mv = (i == 8) ? 8'hff : (8'h01 << i);
      apb(1'b1, ums_pkg::ADDR_MODE, {24'h0, mv});
      rd_chk(ums_pkg::ADDR_MODE, mv); // readback
      chk({24'h0, mode_pins}, {24'h0, mv}); // pin positions
      chk({30'h0, ch1_mode}, {30'h0, mv[1], 1'b0}); // later channel
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(ums_pkg::ADDR_MODE, 8'h00); // mid-run reset
    $display("mode test done");
    // break holds the line low whatever the shifter sends
    apb(1'b1, ums_pkg::ADDR_MODE, 32'h04);
    for (int i = 0; i < 6; i++) begin
      tx_serial <= i[0];
      @(posedge pclk);
      chk({31'h0, txd}, 32'h0); // line held low
    end
    apb(1'b1, ums_pkg::ADDR_MODE, 32'h00);
    for (int i = 0; i < 4; i++) begin
      tx_serial <= i[0];
      repeat (2) @(posedge pclk);
      chk({31'h0, txd}, {31'h0, i[0]}); // line released
    end
    apb(1'b1, ums_pkg::ADDR_STAT, 32'hff);
    st_chk(8'h00); // write ignored
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1); // unmapped word refused
    $display("break and access test done");
    // end of transmission raises the unmasked interrupt
    apb(1'b1, ums_pkg::ADDR_IRQ, 32'hff);
    apb(1'b1, ums_pkg::ADDR_MASK, 32'h80);
    rd_chk(ums_pkg::ADDR_MASK, 8'h80);
    tx_shift_active <= 1'b1;
    repeat (2) @(posedge pclk);
    st_chk(8'h40); // busy shown
    tx_shift_active <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    st_chk(8'h00); // busy gone
    rd_chk(ums_pkg::ADDR_IRQ, 8'h80);
    apb(1'b1, ums_pkg::ADDR_IRQ, 32'h80);
    chk({31'h0, irq}, 32'h0);
    // a masked event is recorded but stays silent
    i_peer.send_frame(5'b10000, 1'b1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(ums_pkg::ADDR_IRQ, 8'h01);
    apb(1'b1, ums_pkg::ADDR_STAT, 32'hff);
    st_chk(8'h09); // parity kept past a status write
    $display("interrupt test done");
    // missing stop, then the line stays low past ten bit times
    i_peer.send_frame(5'b01000, 1'b0);
    repeat (28) @(posedge pclk);
    st_chk(8'h0a); // too early for break
    repeat (20) @(posedge pclk);
    st_chk(8'h10); // break seen
    st_chk(8'h10); // kept while low
    i_peer.set_line(1'b1);
    repeat (3) @(posedge pclk);
    st_chk(8'h00); // cleared once high
    $display("line break test done");
    // a frame that ends while the clock enable is low leaves no trace
    ce <= 1'b0;
    i_peer.send_frame(5'b10000, 1'b1);
    repeat (2) @(posedge pclk);
    ce <= 1'b1;
    st_chk(8'h00); // frozen block misses the event
    $display("clock enable test done");
    wrap_up();
  end
endmodule : tb_uart_mode_and_status
